// >>> design/fmsc_flash_ctrl.sv
// fmsc_flash_ctrl: mode selection, flash strobe sequencing, current
// reduction, readback and converter handshake of a two-channel flash driver
// assumes: level, config and status bits are plain ports from an external
// register file; strobe, aux and battery comparator pins are asynchronous
`timescale 1ns/1ps
`include "fmsc_regs.svh"

module fmsc_flash_ctrl
    import fmsc_pkg::*;
#(
    parameter int FLASH_STEP_CYC = 20000,  // cycles per flash timeout lsb
    parameter int ADC_CONV_CYC   = 200     // cycles of one conversion
) (
    input  wire logic        clk_i,                  // core clock
    input  wire logic        reset_n_i,              // hardware reset pin
    input  wire logic [1:0]  mode_sel_i,             // operating mode
    input  wire logic [1:0]  aux_func_i,             // aux pin function
    input  wire logic        aux_pin_i,              // mask / torch pin
    input  wire logic        strobe_pin_i,           // strobe pin
    input  wire logic        trig_en_i,              // external trigger enable
    input  wire logic        trig_type_i,            // 0 edge, 1 level
    input  wire logic [7:0]  flash_timeout_i,        // flash duration setting
    input  wire logic [7:0]  primary_led_level_i,    // primary channel level
    input  wire logic [7:0]  secondary_led_level_i,  // secondary channel level
    input  wire logic [7:0]  reduced_level_i,        // level while masked
    input  wire logic        pwm_slow_i,             // 1 selects 7.9 kHz
    input  wire logic [5:0]  pwm_duty_i,             // duty, slots minus one
    input  wire logic        load_balance_en_i,      // balance enable
    input  wire logic        balance_dir_i,          // 1 raises primary
    input  wire logic        vin_low_i,              // supply below floor
    input  wire logic        droop_clr_i,            // clears droop flag
    input  wire logic        timeout_clr_i,          // clears timeout flag
    input  wire logic        adc_start_i,            // sets the convert bit
    input  wire logic        adc_src_i,              // 1 die temp, 0 led sense
    input  wire logic [9:0]  led_sense_i,            // led sense sample
    input  wire logic signed [8:0] die_temp_i,       // die temperature, degrees
    output logic [7:0]       emitter1_level_o,       // primary emitter output
    output logic [7:0]       emitter2_level_o,       // secondary emitter output
    output logic             boost_en_o,             // boost converter enable
    output logic             flash_active_o,         // flash or ramp-down
    output logic [7:0]       actual_level_o,         // live level readback
    output logic [7:0]       min_level_o,            // lowest pulse level
    output logic             droop_flag_o,           // battery droop status
    output logic             timeout_flag_o,         // timeout fault
    output logic             adc_busy_o,             // convert bit
    output logic [7:0]       adc_result_hi_o,        // result bits 9..2
    output logic [1:0]       adc_result_lo_o         // result bits 1..0
);

    // ------------------------------------------------------------------------
    // derived counts
    // ------------------------------------------------------------------------
    localparam int DROOP_CYC = `FMSC_DROOP_STEP_NS / `FMSC_CLK_NS;
    localparam int PWM_FAST_CYC = `FMSC_CLK_HZ / (`FMSC_PWM_FAST_HZ * `FMSC_PWM_FAST_SLOT);
    localparam int PWM_SLOW_CYC = `FMSC_CLK_HZ / (`FMSC_PWM_SLOW_HZ * `FMSC_PWM_SLOW_SLOT);

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------
    // balance shift: the level scaled by about 15 percent
    function automatic logic [7:0] lb_shift(input logic [7:0] lvl);
        logic [16:0] p;
        p = 17'(lvl) * 17'(`FMSC_LB_NUM);
        return p[15:8];
    endfunction

    // saturating add and floor subtract of a level
    function automatic logic [7:0] lvl_adj(input logic [7:0] lvl, input logic [7:0] a, input logic up);
        logic [8:0] s;
        s = 9'(lvl) + 9'(a);
        if (up) begin
            return s[8] ? `FMSC_LEVEL_MAX : s[7:0];
        end
        return (lvl > a) ? (lvl - a) : 8'h00;
    endfunction

    // die temperature code, one row per ten degrees
    function automatic logic [9:0] die_code(input logic signed [8:0] t);
        logic signed [8:0] r;
        r = 9'((10'(t) + 10'sd30) / 10'sd10);
        case (r)
            9'sd0:   return 10'd352;
            9'sd1:   return 10'd343;
            9'sd2:   return 10'd334;
            9'sd3:   return 10'd325;
            9'sd4:   return 10'd316;
            9'sd5:   return 10'd306;
            9'sd6:   return 10'd297;
            9'sd7:   return 10'd287;
            9'sd8:   return 10'd278;
            9'sd9:   return 10'd268;
            9'sd10:  return 10'd259;
            9'sd11:  return 10'd249;
            9'sd12:  return 10'd239;
            9'sd13:  return 10'd229;
            9'sd14:  return 10'd219;
            9'sd15:  return 10'd209;
            9'sd16:  return 10'd199;
            9'sd17:  return 10'd189;
            default: return (r < 9'sd0) ? 10'd352 : 10'd179;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    fmsc_state_t q;             // registered state
    fmsc_state_t d;             // next state
    logic        strobe_rise;   // synchronised strobe edge
    logic        start_req;     // a flash start condition
    logic        masked;        // current reduction pin active
    logic [7:0]  tgt1;          // primary flash target
    logic [7:0]  tgt2;          // secondary flash target
    logic [7:0]  low1;          // primary six-bit level
    logic [7:0]  low2;          // secondary six-bit level
    logic        pwm_on;        // indicator pwm phase
    logic        flash_end;     // flash end this cycle

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        d = q;
        // pins pass two flops before use
        d.strobe_s1 = strobe_pin_i;
        d.strobe_s2 = q.strobe_s1;
        d.strobe_prev = q.strobe_s2;
        d.aux_s1 = aux_pin_i;
        d.aux_s2 = q.aux_s1;
        d.vin_s1 = vin_low_i;
        d.vin_s2 = q.vin_s1;
        d.mode_prev = mode_sel_i;
        strobe_rise = q.strobe_s2 & ~q.strobe_prev;

        // flash targets, reduced by the mask pin
        masked = (aux_func_i == `FMSC_AUX_MASK) && q.aux_s2;
        tgt1 = masked ? reduced_level_i : primary_led_level_i;
        tgt2 = masked ? reduced_level_i : secondary_led_level_i;
        // high level bits dropped outside flash
        low1 = primary_led_level_i & `FMSC_LOW6_MASK;
        low2 = secondary_led_level_i & `FMSC_LOW6_MASK;
        // load balance trades current between channels
        if (load_balance_en_i) begin
            tgt1 = lvl_adj(tgt1, lb_shift(tgt1), balance_dir_i);
            tgt2 = lvl_adj(tgt2, lb_shift(tgt2), ~balance_dir_i);
        end

        // indicator pwm slots
        if (q.pwm_pre >= 16'(pwm_slow_i ? PWM_SLOW_CYC - 1 : PWM_FAST_CYC - 1)) begin
            d.pwm_pre = 16'h0000;
            if (pwm_slow_i) begin
                d.pwm_slot = q.pwm_slot + 6'h01;
            end else begin
                d.pwm_slot = {2'h0, q.pwm_slot[3:0] + 4'h1};
            end
        end else begin
            d.pwm_pre = q.pwm_pre + 16'h0001;
        end
        pwm_on = pwm_slow_i ? (q.pwm_slot <= pwm_duty_i) : (q.pwm_slot[3:0] <= pwm_duty_i[3:0]);

        // flash start conditions
        start_req = (mode_sel_i == `FMSC_MODE_FLASH) && (
            (!trig_en_i && q.mode_prev != `FMSC_MODE_FLASH) ||
            (trig_en_i && !trig_type_i && strobe_rise) ||
            (trig_en_i && trig_type_i && strobe_rise));
        flash_end = 1'b0;
        // clears first, so a set later in this cycle wins
        d.droop_flag = q.droop_flag & ~droop_clr_i;
        d.timeout_flag = q.timeout_flag & ~timeout_clr_i;

        // flash sequencer
        case (q.fsm)
            FMSC_IDLE: begin
                if (start_req) begin
                    d.tmr_only = !(trig_en_i && trig_type_i);
                    d.live = 8'h00;
                    d.reached = 1'b0;
                    d.min_lvl = `FMSC_MIN_INIT;
                    d.tmr = 32'(flash_timeout_i + 9'h001) * 32'(FLASH_STEP_CYC);
                    // no flash on an already low battery
                    d.fsm = q.vin_s2 ? FMSC_DONE : FMSC_FLASH;
                end
            end
            FMSC_FLASH: begin
                d.tmr = q.tmr - 32'h1;
                if (q.vin_s2) begin
                    // droop: hold the ramp, step down per interval
                    d.droop_flag = 1'b1;
                    if (q.droop_cnt >= 16'(DROOP_CYC - 1)) begin
                        d.droop_cnt = 16'h0000;
                        d.live = lvl_adj(q.live, 8'h01, 1'b0);
                    end else begin
                        d.droop_cnt = q.droop_cnt + 16'h0001;
                    end
                end else begin
                    d.droop_cnt = 16'h0000;
                    if (q.live < tgt1 && !q.reached) begin
                        d.live = q.live + 8'h01;
                    end else if (q.live > tgt1) begin
                        d.live = tgt1;
                    end
                end
                if (q.live >= tgt1) begin
                    d.reached = 1'b1;
                end
                // lowest level after the ramp or under droop
                if ((q.reached || q.vin_s2) && d.live < q.min_lvl) begin
                    d.min_lvl = d.live;
                end
                if (q.tmr <= 32'h1) begin
                    flash_end = 1'b1;
                    // strobe-length overrun faults at once
                    if (!q.tmr_only) begin
                        d.timeout_flag = 1'b1;
                    end
                end else if (!q.tmr_only && !q.strobe_s2) begin
                    flash_end = 1'b1;
                end else if (mode_sel_i != `FMSC_MODE_FLASH) begin
                    flash_end = 1'b1;
                end
                if (flash_end) begin
                    d.fsm = FMSC_RAMPDN;
                end
            end
            FMSC_RAMPDN: begin
                d.live = lvl_adj(q.live, 8'h01, 1'b0);
                if (q.live <= 8'h01) begin
                    d.fsm = FMSC_DONE;
                    if (q.tmr_only && q.tmr <= 32'h1) begin
                        d.timeout_flag = 1'b1;
                    end
                end
            end
            default: begin
                // rearm once the trigger has gone away
                if (mode_sel_i != `FMSC_MODE_FLASH || (trig_en_i && !q.strobe_s2)) begin
                    d.fsm = FMSC_IDLE;
                end
            end
        endcase

        // converter handshake
        if (adc_start_i && !q.adc_busy) begin
            d.adc_busy = 1'b1;
            d.adc_src = adc_src_i;
            d.adc_cnt = 16'(ADC_CONV_CYC);
        end else if (q.adc_busy) begin
            d.adc_cnt = q.adc_cnt - 16'h0001;
            if (flash_end && q.tmr <= 32'h1 && !q.tmr_only) begin
                d.adc_busy = 1'b0;
            end else if (q.adc_cnt <= 16'h0001) begin
                // result and busy clear land together
                d.adc_busy = 1'b0;
                d.adc_res = q.adc_src ? die_code(die_temp_i) : led_sense_i;
            end
        end

        // emitter levels by mode
        d.out1 = 8'h00;
        d.out2 = 8'h00;
        if (q.fsm == FMSC_FLASH || q.fsm == FMSC_RAMPDN) begin
            d.out1 = d.live;
            d.out2 = (d.live < tgt2) ? d.live : tgt2;
        end else if (mode_sel_i == `FMSC_MODE_IND) begin
            d.out1 = pwm_on ? low1 : 8'h00;
            d.out2 = pwm_on ? low2 : 8'h00;
        end else if (mode_sel_i == `FMSC_MODE_TORCH) begin
            d.out1 = low1;
            d.out2 = low2;
        end else if (mode_sel_i == `FMSC_MODE_STBY && aux_func_i == `FMSC_AUX_TORCH && q.aux_s2) begin
            d.out1 = low1;
            d.out2 = low2;
        end
        // standby without the aux torch pin, and everything else, stays at zero
        d.boost = (d.out1 != 8'h00) || (d.out2 != 8'h00) || (d.fsm == FMSC_FLASH);

        // shutdown: defaults everywhere
        if (!reset_n_i) begin
            d = '0;
            d.min_lvl = `FMSC_MIN_INIT;
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        q <= d;
    end

    // outputs straight from flops, except flash_active_o, decoded from the sequencer state
    assign emitter1_level_o = q.out1;
    assign emitter2_level_o = q.out2;
    assign boost_en_o       = q.boost;
    assign flash_active_o   = (q.fsm == FMSC_FLASH) || (q.fsm == FMSC_RAMPDN);
    assign actual_level_o   = q.live;
    assign min_level_o      = q.min_lvl;
    assign droop_flag_o     = q.droop_flag;
    assign timeout_flag_o   = q.timeout_flag;
    assign adc_busy_o       = q.adc_busy;
    assign adc_result_hi_o  = q.adc_res[9:2];
    assign adc_result_lo_o  = q.adc_res[1:0];

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_shutdown_zero: assert property (disable iff (1'b0) !reset_n_i
        |=> emitter1_level_o == 8'h00 && !boost_en_o) else $error("outputs not zero after shutdown");
    a_standby_zero: assert property (q.fsm == FMSC_IDLE && mode_sel_i == `FMSC_MODE_STBY && aux_func_i != `FMSC_AUX_TORCH
        |=> emitter1_level_o == 8'h00 && emitter2_level_o == 8'h00) else $error("standby drives current");
    a_torch_low6: assert property (q.fsm == FMSC_IDLE && mode_sel_i == `FMSC_MODE_TORCH
        |=> emitter1_level_o[7:6] == 2'h0 && emitter1_level_o == ($past(primary_led_level_i) & 8'h3F))
        else $error("torch level uses high bits");
    a_edge_start: assert property (q.fsm == FMSC_IDLE && !q.vin_s2 && mode_sel_i == `FMSC_MODE_FLASH
        && trig_en_i && strobe_rise |=> flash_active_o) else $error("strobe edge did not start flash");
    a_low_batt_nostart: assert property (q.fsm == FMSC_IDLE && q.vin_s2 && start_req
        |=> !flash_active_o [*3]) else $error("flash started on low battery");
    a_droop_flag: assert property (q.fsm == FMSC_FLASH && q.vin_s2 |=> droop_flag_o)
        else $error("droop flag not set");
    a_droop_rate: assert property (q.fsm == FMSC_FLASH && q.vin_s2 && $past(q.vin_s2)
        && q.droop_cnt != 16'(DROOP_CYC - 1) && !flash_end |=> actual_level_o == $past(actual_level_o))
        else $error("droop stepped too early");
    a_live_readback: assert property (flash_active_o |-> actual_level_o == emitter1_level_o)
        else $error("readback differs from live level");
    a_level_end: assert property (q.fsm == FMSC_FLASH && !q.tmr_only && !q.strobe_s2 && q.tmr > 32'h1
        |=> q.fsm == FMSC_RAMPDN) else $error("strobe fall did not end flash");
    a_adc_done: assert property ($rose(adc_busy_o) |-> adc_busy_o [*2])
        else $error("convert bit cleared too soon");
    a_mask_level: assert property (q.fsm == FMSC_FLASH && masked && !load_balance_en_i && q.reached
        && !q.vin_s2 && !flash_end |=> actual_level_o <= $past(reduced_level_i)) else $error("mask did not reduce");

    c_timer_flash: cover property (q.fsm == FMSC_FLASH && q.tmr_only ##1 q.fsm == FMSC_RAMPDN);
    c_strobe_timeout: cover property (!q.tmr_only && $rose(timeout_flag_o));
    c_droop: cover property (q.fsm == FMSC_FLASH && $rose(droop_flag_o));
    c_adc: cover property ($fell(adc_busy_o));

endmodule

// >>> design/fmsc_pkg.sv
// fmsc_pkg: types of the flash mode and strobe control block
// assumes: widths of counters suit the default module parameters
package fmsc_pkg;

    // flash sequencer states
    typedef enum logic [1:0] {
        FMSC_IDLE,
        FMSC_FLASH,
        FMSC_RAMPDN,
        FMSC_DONE
    } fmsc_flash_t;

    // the whole state of the block
    typedef struct packed {
        logic        strobe_s1;    // strobe pin, first sync stage
        logic        strobe_s2;    // strobe pin, second sync stage
        logic        strobe_prev;  // strobe, one cycle late for edges
        logic        aux_s1;       // aux pin, first sync stage
        logic        aux_s2;       // aux pin, second sync stage
        logic        vin_s1;       // battery floor comparator, stage one
        logic        vin_s2;       // battery floor comparator, stage two
        logic [1:0]  mode_prev;    // mode selector, one cycle late
        fmsc_flash_t fsm;          // flash sequencer
        logic        tmr_only;     // flash length set by timer alone
        logic        reached;      // ramp reached the target once
        logic [7:0]  live;         // current level in use
        logic [7:0]  min_lvl;      // lowest level of the pulse
        logic [31:0] tmr;          // flash duration timer
        logic [15:0] droop_cnt;    // droop step timer
        logic        droop_flag;   // battery droop status
        logic        timeout_flag; // timeout fault
        logic [15:0] pwm_pre;      // pwm slot prescaler
        logic [5:0]  pwm_slot;     // pwm slot index
        logic        adc_busy;     // convert bit
        logic        adc_src;      // latched converter source
        logic [15:0] adc_cnt;      // conversion timer
        logic [9:0]  adc_res;      // last conversion result
        logic [7:0]  out1;         // primary emitter level
        logic [7:0]  out2;         // secondary emitter level
        logic        boost;        // boost converter enable
    } fmsc_state_t;

endpackage

// >>> design/fmsc_regs.svh
// fmsc_regs.svh: named constants of the flash mode and strobe control block
// assumes: included by bare name, definitions only
`ifndef FMSC_REGS_SVH
`define FMSC_REGS_SVH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define FMSC_CLK_HZ        200000000  // core clock rate
`define FMSC_CLK_NS        5          // core clock period
`define FMSC_DROOP_STEP_NS 2000       // droop step-down rate, one lsb per step
`define FMSC_PWM_FAST_HZ   31500      // indicator pwm, sixteenths duty
`define FMSC_PWM_SLOW_HZ   7900       // indicator pwm, sixty-fourths duty
`define FMSC_PWM_FAST_SLOT 16         // duty slots at fast rate
`define FMSC_PWM_SLOW_SLOT 64         // duty slots at slow rate

// ----------------------------------------------------------------------------
// mode and pin function codes
// ----------------------------------------------------------------------------
`define FMSC_MODE_STBY     2'h0       // standby or external torch
`define FMSC_MODE_IND      2'h1       // indicator / low current pwm
`define FMSC_MODE_TORCH    2'h2       // torch light
`define FMSC_MODE_FLASH    2'h3       // flash
`define FMSC_AUX_MASK      2'h1       // aux pin reduces flash current
`define FMSC_AUX_TORCH     2'h2       // aux pin is a hardware torch input

// ----------------------------------------------------------------------------
// level fields and reset values
// ----------------------------------------------------------------------------
`define FMSC_LOW6_MASK     8'h3F      // torch / indicator use six low bits
`define FMSC_LEVEL_MAX     8'hFF      // saturation of an 8-bit level
`define FMSC_MIN_INIT      8'hFF      // lowest-level register after reset
`define FMSC_LB_NUM        9'h026     // balance shift, 38/256 of the level
`define FMSC_LB_SHIFT      8          // divider of the balance shift

`endif

// >>> testbench/fmsc_flash_ctrl_test.sv
// fmsc_flash_ctrl_test: self-checking bench of the flash mode control block
// assumes: flash step of 4 cycles, conversion of 3 cycles
`timescale 1ns/1ps
module fmsc_flash_ctrl_test;
    logic clk_i = 0, reset_n_i = 0, aux = 0, ten = 0, ttyp = 0, fire = 0, clr = 0, go = 0, vin = 0, src = 1, lbe = 0;
    logic [1:0] mode = 0, afn = 0;
    logic [5:0] duty = 0;
    logic [7:0] l1 = 0, l2 = 0, tmo = 8'h03;
    logic [9:0] sense = 0;
    logic signed [8:0] temp = 0;
    wire logic strobe, act, busy, drp, tfl, bst;
    wire logic [7:0] e1, e2, alv, mlv, hi;
    wire logic [1:0] lo;
    int num_errors = 0, samples_checked = 0, cyc = 0, seed = 74, i, k;
    int pw = 200000000 / (31500 * 16);  // clocks per fast pwm slot
    int tq[$] = '{-30, 0, 150};    // die temperatures
    int rq[$] = '{352, 325, 179};  // their codes
    always #2.5 clk_i = ~clk_i;
    fmsc_strobe_model str_u (.clk_i(clk_i), .fire_i(fire), .strobe_o(strobe));
    fmsc_flash_ctrl #(.FLASH_STEP_CYC(4), .ADC_CONV_CYC(3)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .mode_sel_i(mode), .aux_func_i(afn), .aux_pin_i(aux), .strobe_pin_i(strobe), .trig_en_i(ten),
        .trig_type_i(ttyp), .flash_timeout_i(tmo), .primary_led_level_i(l1), .secondary_led_level_i(l2),
        .reduced_level_i(l2), .pwm_slow_i(1'b0), .pwm_duty_i(duty), .load_balance_en_i(lbe),
        .balance_dir_i(1'b0), .vin_low_i(vin), .droop_clr_i(clr), .timeout_clr_i(clr), .adc_start_i(go),
        .adc_src_i(src), .led_sense_i(sense), .die_temp_i(temp), .emitter1_level_o(e1),
        .emitter2_level_o(e2), .boost_en_o(bst), .flash_active_o(act), .actual_level_o(alv),
        .min_level_o(mlv), .droop_flag_o(drp), .timeout_flag_o(tfl), .adc_busy_o(busy),
        .adc_result_hi_o(hi), .adc_result_lo_o(lo));
    // compare one value, count it, report a mismatch at once
    task automatic chk(string nm, logic [9:0] seen, logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // hang guard, far above the expected run length
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(negedge clk_i);
        chk("min_lvl", mlv, 10'h0FF);
        chk("emit1", e1, 10'h000);
        reset_n_i = 1;
        // static modes: torch, external torch, standby
        repeat (10) begin
            l1 = 8'($random(seed));
            l2 = l1 >> 1;
            mode = 2'h2;
            repeat (3) @(negedge clk_i);
            chk("torch1", e1, {2'h0, l1 & 8'h3F});
            chk("torch2", e2, {2'h0, l2 & 8'h3F});
            chk("boost", bst, 10'(((l1 | l2) & 8'h3F) != 0));
            mode = 2'h0;
            afn = 2'h2;
            aux = 1;
            repeat (5) @(negedge clk_i);
            chk("xtorch", e1, {2'h0, l1 & 8'h3F});
            aux = 0;
            repeat (5) @(negedge clk_i);
            chk("standby", e1, 10'h000);
        end
        // indicator pwm: on time over one whole period, high level bits dropped
        l1 = 8'hEA;
        l2 = 8'h55;
        duty = 6'($random(seed)) & 6'h0F;
        mode = 2'h1;
        repeat (2) @(negedge clk_i);
        k = 0;
        repeat (16 * pw) begin
            @(negedge clk_i);
            if (e1 == 8'h2A) k++;
        end
        chk("pwm_on", 10'(k / pw), 10'(duty + 1));
        chk("pwm_rem", 10'(k % pw), 10'h000);
        mode = 2'h0;
        // die temperature conversions, then one led sense conversion
        for (i = 0; i < 4; i++) begin
            src = (i != 3);
            temp = 9'(tq[i % 3]);
            sense = 10'($random(seed));
            go = 1;
            @(negedge clk_i);
            go = 0;
            for (k = 0; k < 50 && busy !== 0; k++) @(negedge clk_i);
            chk("adc_busy", busy, 10'h000);
            chk("adc", {hi, lo}, src ? 10'(rq[i % 3]) : sense);
        end
        // immediate flash, strobe edge with balance, strobe level with mask
        l1 = 8'h08;
        l2 = 8'h04;
        for (i = 0; i < 3; i++) begin
            ten = (i != 0);
            ttyp = (i == 2);
            lbe = (i == 1);
            afn = 2'h1;
            aux = (i == 2);
            mode = 2'h3;
            @(negedge clk_i);
            fire = ten;
            @(negedge clk_i);
            fire = 0;
            for (k = 0; k < 20 && act !== 1; k++) @(negedge clk_i);
            chk("active", act, 10'h001);
            for (k = 0; k < 99 && act !== 0; k++) @(negedge clk_i);
            chk("tmo_flag", tfl, 10'(i != 2));
            chk("min_lvl", mlv, (i == 0) ? 10'h008 : (i == 1) ? 10'h007 : 10'h004);
            mode = 2'h0;
            clr = 1;
            @(negedge clk_i);
            clr = 0;
            @(negedge clk_i);
        end
        aux = 0;
        lbe = 0;
        ten = 0;
        // flash refused on a low battery, no boost
        vin = 1;
        repeat (3) @(negedge clk_i);
        mode = 2'h3;
        repeat (5) @(negedge clk_i);
        chk("lowbat_act", act, 10'h000);
        chk("lowbat_bst", bst, 10'h000);
        mode = 2'h0;
        vin = 0;
        repeat (3) @(negedge clk_i);
        // short diagnostic flash: supply droops two edges in, ramp halts at one
        mode = 2'h3;
        vin = 1;
        @(negedge clk_i);
        for (k = 0; k < 99 && act !== 0; k++) @(negedge clk_i);
        chk("diag_min", mlv, 10'h001);
        chk("droop", drp, 10'h001);
        // main flash at the diagnosed level, longer, no droop
        l1 = mlv;
        l2 = mlv;
        tmo = 8'h07;
        mode = 2'h0;
        vin = 0;
        clr = 1;
        repeat (3) @(negedge clk_i);
        clr = 0;
        mode = 2'h3;
        @(negedge clk_i);
        for (k = 0; k < 99 && act !== 0; k++) @(negedge clk_i);
        chk("main_min", mlv, 10'(l1));
        chk("main_drp", drp, 10'h000);
        // mid-run shutdown returns defaults
        mode = 2'h0;
        reset_n_i = 0;
        @(negedge clk_i);
        chk("rst_tmo", tfl, 10'h000);
        chk("rst_min", mlv, 10'h0FF);
        reset_n_i = 1;
        repeat (2) @(negedge clk_i);
        end_of_test();
    end
endmodule

// >>> testbench/fmsc_strobe_model.sv
// fmsc_strobe_model: far-side strobe pin of the flash control block
// assumes: fire_i pulses one cycle, pin then held high for a fixed span
`timescale 1ns/1ps
module fmsc_strobe_model (
    input  wire logic clk_i,            // core clock
    input  wire logic fire_i,           // request one strobe pulse
    output logic      strobe_o = 1'b0   // strobe pin, low when idle
);
    int cnt = 0;  // remaining high cycles
    // request taken at the rising edge, so no race with the bench's falling-edge drive
    always @(posedge clk_i) begin
        if (fire_i) cnt <= 12;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    // pin moves only at a falling edge, away from sampling
    always @(negedge clk_i) begin
        strobe_o <= (cnt > 0);
    end
endmodule
